// ==== logic/dsh_top.sv ====
// Contract
// - chain pin high selects chain mode; sync low frames clocks into shift register.
// - beyond 24 clocks old bits leave on serial out, changed rising, valid falling.
// - sync rising latches the word and stops shifting until next frame.
// - frame shorter than 24 clocks is discarded, nothing updated.
// - read/write bit one requests readback of addressed channel register.
// - next frame returns ten address bits then fourteen value bits.
// - readback bits change rising; first bit shown at sync falling.
// - two-wire side is slave only, fine up to 400 kHz.
// - slave address is 10101 plus two strap pins.
// - start and stop detected with clock high; repeated start stays busy.
// - accepted address and data bytes acknowledged low in ninth clock.
// - two-wire side accepts writes only; direction bit must be zero.
// - address, pointer, two data bytes, stop updates one channel.
// - without stop, next byte is a new pointer; stop ends anytime.
// - pointer 0xFF starts burst at channel zero, auto incrementing.
// - after channel 39 burst ends, back to pointer plus data.
// - burst ignores bank select; stop ends burst.
// - register select bits in data bytes choose the channel register.
// - frame is bank, read/write, six address, two select, fourteen value.
`timescale 1ns/1ps
`default_nettype none
module dsh_top #(
  parameter int NUM_CH = dsh_pkg::DEF_NUM_CH
) (
  input  wire logic      I_REF_CLK,
  input  wire logic      I_RST_N,
  input  wire logic      I_LINK_SCLK,
  input  wire logic      I_FRAME_SYNC_N,
  input  wire logic      I_SER_DIN,
  input  wire logic      I_CHAIN_ENABLE_PIN,
  input  wire logic      I_SERIAL_PARALLEL_SELECT,
  input  wire logic      I_PROTO_SEL,
  input  wire logic      I_ADDR_STRAP_HI,
  input  wire logic      I_ADDR_STRAP_LO,
  input  wire logic      I_SCL,
  input  wire logic      I_SDA_IN,
  output logic           O_SERIAL_OUT_PIN,
  output logic           O_SDA_OUT,
  output logic           O_SDA_OE,
  output var dsh_pkg::dsh_wr_t O_WR,
  output logic           O_WR_STB,
  output logic           O_BAD_FRAME,
  output logic           O_RB_PENDING,
  output logic           O_SPI_ACTIVE,
  output logic           O_TWI_ACTIVE
);
  import dsh_pkg::*;

  localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);

  if (NUM_CH < 1 || NUM_CH > (1 << CH_W)) begin : g_bad_num_ch
    $error("NUM_CH out of range for six channel bits");
  end
  if (TWI_HALF_CYC < MIN_HALF_CYC) begin : g_bad_clk
    $error("reference clock too slow to oversample the two-wire bus");
  end

  dsh_core_t             r;
  dsh_core_t             nxt;
  logic [DATA_W-1:0]     val_mem [0:MEM_DEPTH-1];
  logic [PIN_W-1:0]      pins_s;
  logic [LINK_CNT_W-1:0] gray_l;
  logic [LINK_CNT_W-1:0] gray_s;
  logic [LINK_CNT_W-1:0] cnt_bin;
  logic [LINK_CNT_W-1:0] frame_bits;
  logic [FRAME_BITS-1:0] link_shift;
  logic [7:0]            rd_idx;
  logic [DATA_W-1:0]     rd_val;
  logic                  sync_s;
  logic                  scl_s;
  logic                  sda_s;
  logic                  spi_mode;
  logic                  twi_mode;
  logic                  sync_rise;
  logic                  frame_ok;
  logic                  tw_start;
  logic                  tw_stop;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  byte_done;
  logic [6:0]            own_addr;

  function automatic logic [LINK_CNT_W-1:0] gray2bin(input logic [LINK_CNT_W-1:0] g);
    logic [LINK_CNT_W-1:0] b;
    b[LINK_CNT_W-1] = g[LINK_CNT_W-1];
    for (int i = LINK_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  dsh_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST_VAL)
  ) u_pin_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_d     ({I_FRAME_SYNC_N, I_SCL, I_SDA_IN, I_SERIAL_PARALLEL_SELECT,
               I_PROTO_SEL, I_ADDR_STRAP_HI, I_ADDR_STRAP_LO}),
    .o_q     (pins_s)
  );

  // edge count crosses as gray code
  dsh_sync #(
    .W       (LINK_CNT_W),
    .RST_VAL ('0)
  ) u_cnt_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (gray_l),
    .o_q     (gray_s)
  );

  dsh_link u_link (
    .i_sclk     (I_LINK_SCLK),
    .i_rst_n    (I_RST_N),
    .i_sync_n   (I_FRAME_SYNC_N),
    .i_din      (I_SER_DIN),
    .i_chain    (I_CHAIN_ENABLE_PIN),
    .i_start    (r.start),
    .i_rb_valid (r.rb_valid),
    .i_rb_word  (r.rb_word),
    .o_gray     (gray_l),
    .o_shift    (link_shift),
    .o_sdo      (O_SERIAL_OUT_PIN)
  );

  assign sync_s     = pins_s[PIN_SYNC];
  assign scl_s      = pins_s[PIN_SCL];
  assign sda_s      = pins_s[PIN_SDA];
  assign spi_mode   = pins_s[PIN_SER] & ~pins_s[PIN_PROTO];
  assign twi_mode   = pins_s[PIN_SER] & pins_s[PIN_PROTO];
  assign own_addr   = {TWI_ADDR_FIXED, pins_s[PIN_STRAP_HI], pins_s[PIN_STRAP_LO]};
  assign cnt_bin    = gray2bin(gray_s);
  assign frame_bits = cnt_bin - r.start;
  assign frame_ok   = frame_bits >= LINK_CNT_W'(FRAME_BITS);
  assign sync_rise  = sync_s & ~r.sync_p;
  assign tw_start   = scl_s & r.scl_p & r.sda_p & ~sda_s;
  assign tw_stop    = scl_s & r.scl_p & ~r.sda_p & sda_s;
  assign scl_rise   = scl_s & ~r.scl_p;
  assign scl_fall   = ~scl_s & r.scl_p;
  assign byte_done  = twi_mode & ~tw_start & ~tw_stop & (r.ist == TW_RECV)
                      & (r.bitcnt == BYTE_BITS) & scl_fall;
  assign rd_idx     = link_shift[CH_MSB:REG_LSB];
  assign rd_val     = r.written[rd_idx] ? val_mem[rd_idx] : '0;

  always_comb begin
    nxt        = r;
    nxt.sync_p = sync_s;
    nxt.scl_p  = scl_s;
    nxt.sda_p  = sda_s;
    nxt.wr_stb = 1'b0;
    nxt.bad    = 1'b0;
    // edge count is quiet while sync is high, so it marks the next frame start
    if (sync_s && r.sync_p) begin
      nxt.start = cnt_bin;
    end
    if (r.wr_stb) begin
      nxt.written[{r.wr.ch, r.wr.regsel}] = 1'b1;
    end
    if (spi_mode && sync_rise) begin
      if (!frame_ok) begin
        nxt.bad = 1'b1;
      end else if (link_shift[RW_POS]) begin
        nxt.rb_valid = 1'b1;
        nxt.rb_word  = {link_shift[FRAME_BITS-1:ADDR_LSB], rd_val};
      end else begin
        nxt.rb_valid  = 1'b0;
        nxt.wr.bank   = link_shift[BANK_POS];
        nxt.wr.ch     = link_shift[CH_MSB:CH_LSB];
        nxt.wr.regsel = link_shift[REG_MSB:REG_LSB];
        nxt.wr.data   = link_shift[DATA_W-1:0];
        nxt.wr_stb    = 1'b1;
      end
    end
    if (!twi_mode) begin
      nxt.ist   = TW_IDLE;
      nxt.burst = 1'b0;
    end else if (tw_start) begin
      nxt.ist    = TW_RECV;
      nxt.kind   = BK_ADDR;
      nxt.bitcnt = '0;
      nxt.burst  = 1'b0;
    end else if (tw_stop) begin
      nxt.ist   = TW_IDLE;
      nxt.burst = 1'b0;
    end else begin
      unique case (r.ist)
        TW_IDLE, TW_IGNORE: begin
          nxt.ist = r.ist;
        end
        TW_RECV: begin
          if (scl_rise && r.bitcnt < BYTE_BITS) begin
            nxt.sh     = {r.sh[6:0], sda_s};
            nxt.bitcnt = r.bitcnt + 4'h1;
          end
          if (byte_done) begin
            nxt.ist = TW_ACK;
            unique case (r.kind)
              BK_ADDR: begin
                if (r.sh[7:1] == own_addr && !r.sh[0]) begin
                  nxt.kind = BK_PTR;
                end else begin
                  nxt.ist = TW_IGNORE;
                end
              end
              BK_PTR: begin
                nxt.kind = BK_DHI;
                if (r.sh == BURST_PTR) begin
                  nxt.burst = 1'b1;
                  nxt.ptr   = '0;
                end else begin
                  nxt.burst = 1'b0;
                  nxt.ptr   = r.sh[PTR_CH_MSB:0];
                end
              end
              BK_DHI: begin
                nxt.dhi  = r.sh;
                nxt.kind = BK_DLO;
              end
              BK_DLO: begin
                nxt.wr.bank   = 1'b0;
                nxt.wr.ch     = r.ptr;
                nxt.wr.regsel = r.dhi[DHI_REG_MSB:DHI_REG_LSB];
                nxt.wr.data   = {r.dhi[DHI_REG_LSB-1:0], r.sh};
                nxt.wr_stb    = 1'b1;
                if (r.burst && r.ptr != LAST_CH) begin
                  nxt.ptr  = r.ptr + 6'h01;
                  nxt.kind = BK_DHI;
                end else begin
                  nxt.burst = 1'b0;
                  nxt.kind  = BK_PTR;
                end
              end
            endcase
          end
        end
        TW_ACK: begin
          if (scl_fall) begin
            nxt.ist    = TW_RECV;
            nxt.bitcnt = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      r        <= '0;
      r.sync_p <= 1'b1;
      r.scl_p  <= 1'b1;
      r.sda_p  <= 1'b1;
      r.ist    <= TW_IDLE;
      r.kind   <= BK_ADDR;
    end else begin
      r <= nxt;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (r.wr_stb) begin
      val_mem[{r.wr.ch, r.wr.regsel}] <= r.wr.data;
    end
  end

  assign O_WR         = r.wr;
  assign O_WR_STB     = r.wr_stb;
  assign O_BAD_FRAME  = r.bad;
  assign O_RB_PENDING = r.rb_valid;
  assign O_SDA_OUT    = 1'b0;
  assign O_SDA_OE     = (r.ist == TW_ACK);
  assign O_SPI_ACTIVE = spi_mode;
  assign O_TWI_ACTIVE = twi_mode;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_good_write;
    spi_mode && sync_rise && frame_ok && !link_shift[RW_POS];
  endsequence
  sequence s_addr_byte(logic hit);
    byte_done && r.kind == BK_ADDR && ((r.sh[7:1] == own_addr && !r.sh[0]) == hit);
  endsequence
  sequence s_last_data;
    byte_done && r.kind == BK_DLO;
  endsequence
  sequence s_ptr_byte;
    byte_done && r.kind == BK_PTR;
  endsequence

  AST_SPI_LATCH: assert property (s_good_write |=> O_WR_STB
      && O_WR.ch == $past(link_shift[CH_MSB:CH_LSB])
      && O_WR.data == $past(link_shift[DATA_W-1:0]))
    else $error("good frame did not produce the latched write");
  AST_BAD_FRAME: assert property (spi_mode && sync_rise && !frame_ok
      |=> O_BAD_FRAME && !O_WR_STB)
    else $error("short frame was not discarded");
  AST_RB_WORD: assert property (spi_mode && sync_rise && frame_ok && link_shift[RW_POS]
      |=> O_RB_PENDING
      && r.rb_word[FRAME_BITS-1:ADDR_LSB] == $past(link_shift[FRAME_BITS-1:ADDR_LSB]))
    else $error("readback word lacks the request address");
  AST_RB_CLEAR: assert property (s_good_write |=> !O_RB_PENDING)
    else $error("write frame left a readback armed");
  AST_WR_PULSE: assert property (O_WR_STB |=> !O_WR_STB)
    else $error("write strobe longer than one cycle");
  AST_BAD_PULSE: assert property (O_BAD_FRAME |=> !O_BAD_FRAME)
    else $error("bad frame flag longer than one cycle");
  AST_ADDR_ACK: assert property (s_addr_byte(1'b1) |=> O_SDA_OE && !O_SDA_OUT)
    else $error("own address not acknowledged");
  AST_ADDR_NAK: assert property (s_addr_byte(1'b0) |=> !O_SDA_OE [*2])
    else $error("foreign address acknowledged");
  AST_PTR_ACK: assert property (s_ptr_byte |=> O_SDA_OE && !O_SDA_OUT)
    else $error("pointer byte not acknowledged");
  AST_ACK_END: assert property (O_SDA_OE && scl_fall |=> !O_SDA_OE)
    else $error("acknowledge held past the ninth clock");
  AST_START_RECV: assert property (twi_mode && tw_start
      |=> r.ist == TW_RECV && r.kind == BK_ADDR && r.bitcnt == '0 && !r.burst)
    else $error("start did not open an address byte");
  AST_STOP_IDLE: assert property (twi_mode && tw_stop |=> r.ist == TW_IDLE && !r.burst)
    else $error("stop did not end the transfer");
  AST_IGNORE_QUIET: assert property (r.ist == TW_IGNORE && !tw_start |=> !O_SDA_OE)
    else $error("ignored transfer was acknowledged");
  AST_IDLE_OFF: assert property (!twi_mode |=> r.ist == TW_IDLE && !O_SDA_OE)
    else $error("two-wire slave active outside two-wire mode");
  AST_BURST_START: assert property (byte_done && r.kind == BK_PTR && r.sh == BURST_PTR
      |=> r.burst && r.ptr == '0 && r.kind == BK_DHI)
    else $error("burst pointer did not start at channel zero");
  AST_PTR_CH: assert property ((s_ptr_byte and (r.sh != BURST_PTR))
      |=> !r.burst && r.kind == BK_DHI && r.ptr == $past(r.sh[PTR_CH_MSB:0]))
    else $error("pointer byte did not select its channel");
  AST_DHI_HOLD: assert property (byte_done && r.kind == BK_DHI
      |=> r.kind == BK_DLO && r.dhi == $past(r.sh))
    else $error("high data byte not kept");
  AST_BURST_STEP: assert property ((s_last_data and (r.burst && r.ptr != LAST_CH))
      |=> r.burst && r.kind == BK_DHI && r.ptr == $past(r.ptr) + 6'h01)
    else $error("burst pointer did not advance");
  AST_BURST_END: assert property ((s_last_data and (r.burst && r.ptr == LAST_CH))
      |=> !r.burst && r.kind == BK_PTR && O_WR_STB)
    else $error("burst ran past the last channel");
  AST_TWI_PAYLOAD: assert property (s_last_data |=> O_WR_STB && !O_WR.bank
      && O_WR.data[7:0] == $past(r.sh)
      && O_WR.regsel == $past(r.dhi[DHI_REG_MSB:DHI_REG_LSB]))
    else $error("two-wire write payload misassembled");
  AST_OE_MODE: assert property (O_SDA_OE |-> $past(twi_mode))
    else $error("data line driven outside two-wire mode");
endmodule
`default_nettype wire

// ==== logic/dsh_pkg.sv ====
`default_nettype none
package dsh_pkg;

  // serial frame layout, msb first
  localparam int FRAME_BITS = 24;
  localparam int BANK_POS   = 23;
  localparam int RW_POS     = 22;
  localparam int CH_MSB     = 21;
  localparam int CH_LSB     = 16;
  localparam int REG_MSB    = 15;
  localparam int REG_LSB    = 14;
  localparam int ADDR_LSB   = 14;
  localparam int DATA_W     = 14;
  localparam int CH_W       = 6;
  localparam int REG_W      = 2;
  localparam int MEM_DEPTH  = 256;
  localparam int DEF_NUM_CH = 40;

  // link edge counter wraps after this many bits; 10 bits covers 42 chained parts
  localparam int LINK_CNT_W = 10;

  // two-wire protocol constants
  localparam logic [7:0] BURST_PTR      = 8'hFF;
  localparam logic [4:0] TWI_ADDR_FIXED = 5'h15;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam int         PTR_CH_MSB     = 5;
  localparam int         DHI_REG_MSB    = 7;
  localparam int         DHI_REG_LSB    = 6;

  // timing: fastest bus clock against the reference clock
  localparam int REF_CLK_NS   = 20;
  localparam int TWI_MAX_KHZ  = 400;
  localparam int TWI_PER_NS   = 1000000 / TWI_MAX_KHZ;
  localparam int TWI_HALF_CYC = TWI_PER_NS / 2 / REF_CLK_NS;
  localparam int MIN_HALF_CYC = 4;

  // synchronised pin vector positions and reset value
  localparam int         PIN_W        = 7;
  localparam int         PIN_SYNC     = 6;
  localparam int         PIN_SCL      = 5;
  localparam int         PIN_SDA      = 4;
  localparam int         PIN_SER      = 3;
  localparam int         PIN_PROTO    = 2;
  localparam int         PIN_STRAP_HI = 1;
  localparam int         PIN_STRAP_LO = 0;
  localparam logic [6:0] PIN_RST_VAL  = 7'h70;

  typedef struct packed {
    logic              bank;
    logic [CH_W-1:0]   ch;
    logic [REG_W-1:0]  regsel;
    logic [DATA_W-1:0] data;
  } dsh_wr_t;

  typedef enum logic [1:0] {
    TW_IDLE   = 2'h0,
    TW_RECV   = 2'h1,
    TW_ACK    = 2'h3,
    TW_IGNORE = 2'h2
  } dsh_twst_t;

  typedef enum logic [1:0] {
    BK_ADDR = 2'h0,
    BK_PTR  = 2'h1,
    BK_DHI  = 2'h3,
    BK_DLO  = 2'h2
  } dsh_kind_t;

  typedef struct packed {
    logic [LINK_CNT_W-1:0] cnt;
    logic [LINK_CNT_W-1:0] gray;
    logic [FRAME_BITS-1:0] shift;
  } dsh_link_t;

  typedef struct packed {
    logic                  sync_p;
    logic                  scl_p;
    logic                  sda_p;
    logic [LINK_CNT_W-1:0] start;
    dsh_wr_t               wr;
    logic                  wr_stb;
    logic                  bad;
    logic                  rb_valid;
    logic [FRAME_BITS-1:0] rb_word;
    logic [MEM_DEPTH-1:0]  written;
    dsh_twst_t             ist;
    dsh_kind_t             kind;
    logic [3:0]            bitcnt;
    logic [7:0]            sh;
    logic [7:0]            dhi;
    logic [CH_W-1:0]       ptr;
    logic                  burst;
  } dsh_core_t;

endpackage
`default_nettype wire

// ==== logic/dsh_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsh_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [1:0][W-1:0] r;
  logic [1:0][W-1:0] nxt;

  always_comb begin
    nxt[0] = i_d;
    nxt[1] = r[0];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= nxt;
    end
  end

  assign o_q = r[1];
endmodule
`default_nettype wire

// ==== logic/dsh_link.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsh_link (
  input  wire logic                             i_sclk,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_sync_n,
  input  wire logic                             i_din,
  input  wire logic                             i_chain,
  input  wire logic [dsh_pkg::LINK_CNT_W-1:0]   i_start,
  input  wire logic                             i_rb_valid,
  input  wire logic [dsh_pkg::FRAME_BITS-1:0]   i_rb_word,
  output logic      [dsh_pkg::LINK_CNT_W-1:0]   o_gray,
  output logic      [dsh_pkg::FRAME_BITS-1:0]   o_shift,
  output logic                                  o_sdo
);
  import dsh_pkg::*;

  dsh_link_t             r;
  dsh_link_t             nxt;
  logic                  out_r;
  logic                  out_nxt;
  logic [LINK_CNT_W-1:0] fcnt;
  logic                  in_word;
  logic [4:0]            idx;

  // bits seen in this frame; start is frozen by the other domain while sync is low
  assign fcnt    = r.cnt - i_start;
  assign in_word = fcnt < LINK_CNT_W'(FRAME_BITS);
  assign idx     = 5'(FRAME_BITS - 1) - fcnt[4:0];

  always_comb begin
    nxt      = r;
    nxt.cnt  = r.cnt + LINK_CNT_W'(1);
    nxt.gray = nxt.cnt ^ (nxt.cnt >> 1);
    if (i_chain || in_word) begin
      nxt.shift = {r.shift[FRAME_BITS-2:0], i_din};
    end
  end

  // input sampled on the falling clock edge only while the frame is open
  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else if (!i_sync_n) begin
      r <= nxt;
    end
  end

  always_comb begin
    out_nxt = (i_rb_valid && in_word) ? i_rb_word[idx] : r.shift[FRAME_BITS-1];
  end

  // output changes on the rising edge, valid at the next falling edge
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_r <= 1'b0;
    end else if (!i_sync_n) begin
      out_r <= out_nxt;
    end
  end

  // first readback bit appears straight from the falling frame sync
  assign o_sdo   = i_sync_n ? 1'b0 :
                   (fcnt == '0) ? (i_rb_valid & i_rb_word[FRAME_BITS-1]) : out_r;
  assign o_gray  = r.gray;
  assign o_shift = r.shift;
endmodule
`default_nettype wire

// ==== test/dsh_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsh_host_model (
  input  wire logic i_sdo,
  input  wire logic i_sda,
  output logic      o_sclk,
  output logic      o_sync_n,
  output logic      o_din,
  output logic      o_scl,
  output logic      o_sda
);
  localparam realtime SPI_HALF = 62.5;
  localparam realtime TWI_Q    = 625.0;

  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_din = 1'b0;
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // gated clock idling high; exactly n clocks while sync is low
  task automatic spi_frame(input int n, input logic [47:0] w, output logic [47:0] cap);
    cap = '0;
    #7 o_sync_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      o_din = w[i];
      #SPI_HALF o_sclk = 1'b0;
      cap = {cap[46:0], i_sdo};
      #SPI_HALF o_sclk = 1'b1;
    end
    #100 o_sync_n = 1'b1;
    o_din = ~o_din;
    #200;
  endtask

  task automatic twi_start();
    o_sda = 1'b1;
    #TWI_Q o_scl = 1'b1;
    #TWI_Q o_sda = 1'b0;
    #TWI_Q o_scl = 1'b0;
  endtask

  // 400 kHz bit period; data released in the ninth clock to sample the ack
  task automatic twi_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #TWI_Q o_sda = b[i];
      #TWI_Q o_scl = 1'b1;
      #(2 * TWI_Q) o_scl = 1'b0;
    end
    #TWI_Q o_sda = 1'b1;
    #TWI_Q o_scl = 1'b1;
    #TWI_Q ack = i_sda;
    #TWI_Q o_scl = 1'b0;
  endtask

  task automatic twi_stop();
    #TWI_Q o_sda = 1'b0;
    #TWI_Q o_scl = 1'b1;
    #TWI_Q o_sda = 1'b1;
    #(2 * TWI_Q);
  endtask
endmodule
`default_nettype wire

// ==== test/test_dac_serial_host_interface.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_dac_serial_host_interface;
  import dsh_pkg::*;
  localparam int NCH = 8;
  logic        clk, rst_n, chain, ser_sel, proto, strap_hi, strap_lo;
  logic        sclk, sync_n, din, scl, m_sda, sda_w, serial_out_pin, sda_out, sda_oe;
  logic        wr_stb, bad, rb_pend, spi_act, twi_act, ack;
  logic [7:0]  adr;
  logic [23:0] req;
  logic [47:0] cap;
  dsh_wr_t     wr;
  dsh_wr_t     wq[$];
  int          fails, n_compared, nbad;

  // open-drain data line with pull-up
  assign sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;

  dsh_top #(.NUM_CH(NCH)) dut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_LINK_SCLK(sclk), .I_FRAME_SYNC_N(sync_n),
    .I_SER_DIN(din), .I_CHAIN_ENABLE_PIN(chain), .I_SERIAL_PARALLEL_SELECT(ser_sel),
    .I_PROTO_SEL(proto), .I_ADDR_STRAP_HI(strap_hi), .I_ADDR_STRAP_LO(strap_lo),
    .I_SCL(scl), .I_SDA_IN(sda_w), .O_SERIAL_OUT_PIN(serial_out_pin), .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe), .O_WR(wr), .O_WR_STB(wr_stb), .O_BAD_FRAME(bad),
    .O_RB_PENDING(rb_pend), .O_SPI_ACTIVE(spi_act), .O_TWI_ACTIVE(twi_act)
  );

  dsh_host_model host (
    .i_sdo(serial_out_pin), .i_sda(sda_w), .o_sclk(sclk), .o_sync_n(sync_n),
    .o_din(din), .o_scl(scl), .o_sda(m_sda)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wq.push_back(wr);
    end
    if (bad === 1'b1) begin
      nbad++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_wr(input dsh_wr_t e);
    chk(wq.size(), 1);
    if (wq.size() > 0) begin
      chk({9'h000, wq.pop_front()}, {9'h000, e});
    end
    wq.delete();
  endtask

  task automatic restart(input logic c, input logic p);
    @(negedge clk);
    rst_n = 1'b0;
    chain = c;
    proto = p;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    wq.delete();
    nbad = 0;
  endtask

  function automatic logic [23:0] word(logic b, logic rw, logic [5:0] ch, logic [1:0] rs,
                                       logic [13:0] d);
    return {b, rw, ch, rs, d};
  endfunction

  task automatic send(input logic [7:0] b, input logic exp_ack);
    host.twi_byte(b, ack);
    chk(ack, exp_ack);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #1500000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    chain = 1'b0;
    ser_sel = 1'b1;
    proto = 1'b0;
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    fails = 0;
    n_compared = 0;
    nbad = 0;
    // standalone port: write, short frame, readback
    restart(1'b0, 1'b0);
    chk({spi_act, twi_act}, 2'b10);
    host.spi_frame(24, 48'(word(1'b0, 1'b0, 6'h05, 2'h2, 14'h1234)), cap);
    expect_wr('{1'b0, 6'h05, 2'h2, 14'h1234});
    host.spi_frame(10, 48'h3FF, cap);
    chk(nbad, 1);
    chk(wq.size(), 0);
    req = word(1'b0, 1'b1, 6'h05, 2'h2, 14'h3FFF);
    host.spi_frame(24, 48'(req), cap);
    chk({rb_pend, 1'(wq.size())}, 2'b10);
    host.spi_frame(24, 48'h0, cap);
    chk(cap[23:0], {req[23:14], 14'h1234});
    chk(rb_pend, 1'b0);
    // chained: 48 clocks, first word ripples out, last word is kept
    restart(1'b1, 1'b0);
    req = word(1'b0, 1'b0, 6'h11, 2'h1, 14'h2AAA);
    host.spi_frame(48, {req, word(1'b1, 1'b0, 6'h22, 2'h3, 14'h1555)}, cap);
    chk(cap[23:0], req);
    expect_wr('{1'b1, 6'h22, 2'h3, 14'h1555});
    // two-wire port
    restart(1'b0, 1'b1);
    chk({spi_act, twi_act}, 2'b01);
    adr = {TWI_ADDR_FIXED, strap_hi, strap_lo, 1'b0};
    host.twi_start();
    send(adr, 1'b0);
    send(8'h07, 1'b0);
    send(8'h6B, 1'b0);
    send(8'hCD, 1'b0);
    host.twi_stop();
    expect_wr('{1'b0, 6'h07, 2'h1, 14'h2BCD});
    host.twi_start();
    send(adr, 1'b0);
    send(8'h03, 1'b0);
    send(8'h40, 1'b0);
    host.twi_start();
    send(adr, 1'b0);
    send(8'h04, 1'b0);
    send(8'h00, 1'b0);
    send(8'h11, 1'b0);
    host.twi_stop();
    expect_wr('{1'b0, 6'h04, 2'h0, 14'h0011});
    host.twi_start();
    send(adr ^ 8'h04, 1'b1);
    send(8'h07, 1'b1);
    send(8'h6B, 1'b1);
    host.twi_stop();
    host.twi_start();
    send(adr | 8'h01, 1'b1);
    host.twi_stop();
    chk(wq.size(), 0);
    host.twi_start();
    send(adr, 1'b0);
    send(BURST_PTR, 1'b0);
    for (int i = 0; i < NCH; i++) begin
      send({2'h2, 6'(i)}, 1'b0);
      send(8'(i * 3), 1'b0);
      expect_wr('{1'b0, 6'(i), 2'h2, {6'(i), 8'(i * 3)}});
    end
    send(8'h02, 1'b0);
    send(8'hC1, 1'b0);
    send(8'h5A, 1'b0);
    expect_wr('{1'b0, 6'h02, 2'h3, 14'h015A});
    host.twi_stop();
    repeat (10) @(negedge clk);
    chk(sda_oe, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
